// ---- irq_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_core_model
   import irq_dist_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // behaviour
   input wire logic [3:0] enable,
   input wire logic [3:0] delay,
   // core side
   input wire core_req_type [3:0] req,
   output var core_ack_type [3:0] ack
);
   logic [3:0] take;
   logic [3:0][9:0] take_id;
   int cnt [4];
   // three-cycle guard: the request only drops two edges after our acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         take <= '0;
         take_id <= '0;
         cnt <= '{default: 0};
      end else begin
         for (int c = 0; c < NUM_CORES; c++) begin
            take[c] <= 1'b0;
            if (cnt[c] < 0) begin
               cnt[c] <= cnt[c] + 1;
            end else if (enable[c] && req[c].valid) begin
               if (cnt[c] >= int'(delay)) begin
                  take[c] <= 1'b1;
                  take_id[c] <= req[c].id;
                  cnt[c] <= -3;
               end else begin
                  cnt[c] <= cnt[c] + 1;
               end
            end else begin
               cnt[c] <= 0;
            end
         end
      end
   end
   // id is meaningless between pulses, so it never shows the last value
   always_comb begin
      for (int c = 0; c < NUM_CORES; c++) begin
         ack[c].take = take[c];
         ack[c].id = take[c] ? take_id[c] : ~take_id[c];
      end
   end
endmodule
`default_nettype wire

// ---- irq_dist_pkg.sv ----
package irq_dist_pkg;
   localparam int NUM_CORES = 4;
   localparam int NUM_SGI = 16;
   localparam int SPI_BASE = 32;
   localparam int NUM_SPI = 224;
   localparam int ID_TIMER = 29;
   localparam int ID_LEGACY = 31;
   localparam int IDS_PER_STEP = 32;
   localparam logic [4:0] LINE_COUNT_MAX = 5'h07;
   localparam logic [11:0] PSET_BASE = 12'h280;
   localparam logic [11:0] PSET_LAST = 12'h29c;
   localparam logic [11:0] PRIO_BASE = 12'h400;
   localparam logic [11:0] PRIO_LAST = 12'h4fc;
   localparam logic [11:0] ROUTE_BASE = 12'h800;
   localparam logic [11:0] ROUTE_LAST = 12'h8fc;
   localparam logic [11:0] CFG_BASE = 12'hc00;
   localparam logic [11:0] CFG_LAST = 12'hc3c;
   localparam logic [11:0] LEVEL_BASE = 12'hd00;
   localparam logic [11:0] LEVEL_LAST = 12'hd1c;
   localparam logic [11:0] SWTRIG_ADDR = 12'hf00;
   localparam int PRIO_LSB = 4;
   localparam int SW_ID_LSB = 0;
   localparam int SW_MASK_LSB = 16;
   localparam int SW_FILT_LSB = 24;
   localparam logic [1:0] FILT_LIST = 2'b00;
   localparam logic [1:0] FILT_OTHERS = 2'b01;
   localparam logic [1:0] FILT_SELF = 2'b10;
   localparam logic [3:0] PRIO_LOWEST = 4'hf;
   localparam logic [1:0] CFG_PRIVATE = 2'b10;
   localparam logic [9:0] SPURIOUS_ID = 10'h3ff;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic valid;
      logic [9:0] id;
      logic [3:0] prio;
      logic [1:0] src;
   } core_req_type;

   typedef struct packed {
      logic take;
      logic [9:0] id;
   } core_ack_type;
endpackage

// ---- irq_distributor.sv ----
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module irq_distributor
   import irq_dist_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire apb_req_type bus_in,
   input wire logic [1:0] access_core,
   output apb_rsp_type bus_out,
   // configuration
   input wire logic [4:0] line_count_field,
   input wire logic [1:0] core_count,
   // interrupt sources
   input wire logic [NUM_SPI-1:0] irq_lines,
   input wire logic [3:0][1:0] private_lines,
   input wire logic [3:0] legacy_irq_pin_n,
   // core interfaces
   input wire core_ack_type [3:0] ack,
   output core_req_type [3:0] req
);
   typedef struct packed {
      logic [3:0][31:0][3:0] prio_priv;
      logic [NUM_SPI-1:0][3:0] prio_spi;
      logic [NUM_SPI-1:0][3:0] route;
      logic [NUM_SPI-1:0][1:0] cfg;
      logic [3:0][15:0] sgi_model;
      logic [NUM_SPI-1:0][3:0] spi_pend;
      logic [NUM_SPI-1:0] line_prev;
      logic [3:0][15:0] sgi_pend;
      logic [3:0][15:0][1:0] sgi_src;
      logic [3:0][1:0] ppi_prev;
      logic [3:0][1:0] ppi_pend;
      core_req_type [3:0] req;
      apb_rsp_type rsp;
   } state_type;

   state_type s;
   state_type next_s;

   logic [31:0] rd;
   logic [31:0] wd;
   logic wr;
   logic [11:0] off;
   logic [3:0] cm;
   logic [3:0] dest;
   logic [3:0] self_hot;
   logic [1:0] src;
   logic [3:0] pr;
   logic pend;
   logic found;
   int id;

   // line count above the top encoding is reserved, treated as no lines
   function automatic logic id_present(input int i, input logic [4:0] lcf);
      int lim;
      lim = IDS_PER_STEP;
      if (lcf <= LINE_COUNT_MAX) begin
         lim = IDS_PER_STEP * (int'(lcf) + 1);
      end
      return (i < lim);
   endfunction

   function automatic logic [3:0] cores_mask(input logic [1:0] cc);
      return 4'hf >> (2'd3 - cc);
   endfunction

   always_comb begin
      next_s = s;
      rd = '0;
      off = bus_in.paddr;
      wd = bus_in.pwdata;
      cm = cores_mask(core_count);
      self_hot = 4'h1 << access_core;
      dest = '0;
      src = '0;
      pr = '0;
      pend = 1'b0;
      found = 1'b0;
      id = 0;
      // ready is registered, so every transfer has no wait state
      next_s.rsp.pready = bus_in.psel & ~bus_in.penable;
      next_s.rsp.pslverr = 1'b0;
      wr = bus_in.psel & bus_in.penable & s.rsp.pready & bus_in.pwrite;

      // read decode, sampled in the setup cycle
      if (off >= PRIO_BASE && off <= PRIO_LAST) begin
         for (int b = 0; b < 4; b++) begin
            id = int'({off[7:2], 2'(b)});
            if (id < NUM_SGI || id >= ID_TIMER) begin
               if (id < SPI_BASE) begin
                  rd[b*8+PRIO_LSB +: 4] = s.prio_priv[access_core][id];
               end else if (id_present(id, line_count_field)) begin
                  rd[b*8+PRIO_LSB +: 4] = s.prio_spi[id-SPI_BASE];
               end
            end
         end
      end else if (off >= ROUTE_BASE && off <= ROUTE_LAST) begin
         for (int b = 0; b < 4; b++) begin
            id = int'({off[7:2], 2'(b)});
            if (id >= ID_TIMER && id < SPI_BASE) begin
               rd[b*8 +: 4] = self_hot;
            end else if (id >= SPI_BASE && id_present(id, line_count_field)) begin
               rd[b*8 +: 4] = s.route[id-SPI_BASE];
            end
         end
      end else if (off >= CFG_BASE && off <= CFG_LAST) begin
         for (int j = 0; j < 16; j++) begin
            id = int'({off[5:2], 4'(j)});
            if (id < NUM_SGI) begin
               rd[2*j +: 2] = {1'b1, s.sgi_model[access_core][id]};
            end else if (id == ID_TIMER || id == ID_TIMER + 1) begin
               rd[2*j +: 2] = CFG_PRIVATE;
            end else if (id >= SPI_BASE && id_present(id, line_count_field)) begin
               rd[2*j +: 2] = s.cfg[id-SPI_BASE];
            end
         end
      end else if (off >= LEVEL_BASE && off <= LEVEL_LAST) begin
         for (int j = 0; j < 32; j++) begin
            id = int'({off[4:2], 5'(j)});
            if (id >= SPI_BASE && id_present(id, line_count_field)) begin
               rd[j] = irq_lines[id-SPI_BASE];
            end
         end
      end
      if (bus_in.psel && !bus_in.penable) begin
         next_s.rsp.prdata = bus_in.pwrite ? 32'h0 : rd;
      end

      // acknowledges clear first, so a set in the same cycle wins unless a line or pending-set write finds a shared id still pending on another core
      for (int c = 0; c < NUM_CORES; c++) begin
         if (ack[c].take) begin
            id = int'(ack[c].id);
            if (id < NUM_SGI) begin
               src = s.sgi_src[c][id];
               next_s.sgi_pend[c][id] = 1'b0;
               if (s.sgi_model[src][id]) begin
                  for (int k = 0; k < NUM_CORES; k++) begin
                     if (s.sgi_src[k][id] == src) begin
                        next_s.sgi_pend[k][id] = 1'b0;
                     end
                  end
               end
            end else if (id == ID_TIMER || id == ID_TIMER + 1) begin
               next_s.ppi_pend[c][id-ID_TIMER] = 1'b0;
            end else if (id >= SPI_BASE && id < SPI_BASE + NUM_SPI) begin
               if (s.cfg[id-SPI_BASE][0]) begin
                  next_s.spi_pend[id-SPI_BASE] = '0;
               end else begin
                  next_s.spi_pend[id-SPI_BASE][c] = 1'b0;
               end
            end
         end
      end

      // private timer and watchdog lines are edge sensitive
      next_s.ppi_prev = private_lines;
      for (int c = 0; c < NUM_CORES; c++) begin
         for (int k = 0; k < 2; k++) begin
            if (private_lines[c][k] && !s.ppi_prev[c][k]) begin
               next_s.ppi_pend[c][k] = 1'b1;
            end
         end
      end

      // shared lines latch the route only when not yet pending
      next_s.line_prev = irq_lines;
      for (int i = 0; i < NUM_SPI; i++) begin
         if (id_present(i + SPI_BASE, line_count_field)) begin
            pend = s.cfg[i][1] ? (irq_lines[i] & ~s.line_prev[i]) : irq_lines[i];
            if (pend && next_s.spi_pend[i] == 4'h0) begin
               next_s.spi_pend[i] = s.route[i] & cm;
            end
         end
      end

      // register writes take effect at the completing access edge
      if (wr) begin
         if (off >= PRIO_BASE && off <= PRIO_LAST) begin
            for (int b = 0; b < 4; b++) begin
               id = int'({off[7:2], 2'(b)});
               if (id < NUM_SGI || (id >= ID_TIMER && id < SPI_BASE)) begin
                  next_s.prio_priv[access_core][id] = wd[b*8+PRIO_LSB +: 4];
               end else if (id >= SPI_BASE && id_present(id, line_count_field)) begin
                  next_s.prio_spi[id-SPI_BASE] = wd[b*8+PRIO_LSB +: 4];
               end
            end
         end else if (off >= ROUTE_BASE && off <= ROUTE_LAST) begin
            for (int b = 0; b < 4; b++) begin
               id = int'({off[7:2], 2'(b)});
               if (id >= SPI_BASE && id_present(id, line_count_field)) begin
                  next_s.route[id-SPI_BASE] = wd[b*8 +: 4];
               end
            end
         end else if (off >= CFG_BASE && off <= CFG_LAST) begin
            for (int j = 0; j < 16; j++) begin
               id = int'({off[5:2], 4'(j)});
               if (id < NUM_SGI) begin
                  next_s.sgi_model[access_core][id] = wd[2*j];
               end else if (id >= SPI_BASE && id_present(id, line_count_field)) begin
                  next_s.cfg[id-SPI_BASE] = wd[2*j +: 2];
               end
            end
         end else if (off >= PSET_BASE && off <= PSET_LAST) begin
            for (int j = 0; j < 32; j++) begin
               id = int'({off[4:2], 5'(j)});
               if (wd[j] && id >= SPI_BASE && id_present(id, line_count_field)) begin
                  if (next_s.spi_pend[id-SPI_BASE] == 4'h0) begin
                     next_s.spi_pend[id-SPI_BASE] = s.route[id-SPI_BASE] & cm;
                  end
               end
            end
         end else if (off == SWTRIG_ADDR) begin
            // bits 23:20 are assumed zero and are not looked at
            case (wd[SW_FILT_LSB +: 2])
               FILT_LIST: dest = wd[SW_MASK_LSB +: 4];
               FILT_OTHERS: dest = ~self_hot;
               FILT_SELF: dest = self_hot;
               default: dest = 4'h0;
            endcase
            dest = dest & cm;
            id = int'(wd[SW_ID_LSB +: 10]);
            if (id < NUM_SGI) begin
               for (int c = 0; c < NUM_CORES; c++) begin
                  if (dest[c]) begin
                     next_s.sgi_pend[c][id] = 1'b1;
                     next_s.sgi_src[c][id] = access_core;
                  end
               end
            end else if (id >= SPI_BASE && id_present(id, line_count_field)) begin
               next_s.spi_pend[id-SPI_BASE] = next_s.spi_pend[id-SPI_BASE] | dest;
            end
            // ids 16-31 and ids past the implemented range are dropped
         end
      end

      // per-core selection: lowest level wins, ties go to the lower id
      for (int c = 0; c < NUM_CORES; c++) begin
         next_s.req[c].valid = 1'b0;
         next_s.req[c].id = SPURIOUS_ID;
         next_s.req[c].prio = PRIO_LOWEST;
         next_s.req[c].src = 2'b00;
         found = 1'b0;
         for (int i = 0; i < SPI_BASE + NUM_SPI; i++) begin
            pend = 1'b0;
            pr = PRIO_LOWEST;
            src = 2'b00;
            if (i < NUM_SGI) begin
               pend = s.sgi_pend[c][i];
               pr = s.prio_priv[c][i];
               src = s.sgi_src[c][i];
            end else if (i >= ID_TIMER && i < ID_LEGACY) begin
               pend = s.ppi_pend[c][i-ID_TIMER];
               pr = s.prio_priv[c][i];
            end else if (i == ID_LEGACY) begin
               pend = ~legacy_irq_pin_n[c];
               pr = s.prio_priv[c][i];
            end else if (i >= SPI_BASE && id_present(i, line_count_field)) begin
               pend = s.spi_pend[i-SPI_BASE][c];
               pr = s.prio_spi[i-SPI_BASE];
            end
            // strict compare against 0xf start keeps 0xf from ever winning
            if (cm[c] && pend && pr < next_s.req[c].prio) begin
               found = 1'b1;
               next_s.req[c].prio = pr;
               next_s.req[c].id = 10'(i);
               next_s.req[c].src = src;
            end
         end
         next_s.req[c].valid = found;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus_out = s.rsp;
   assign req = s.req;
endmodule
`default_nettype wire

// ---- irq_distributor_prio_route_cfg_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_distributor_prio_route_cfg_test
   import irq_dist_pkg::*;
;
   typedef struct {logic w; logic [11:0] a; logic [1:0] core; logic [4:0] lc;
      logic [31:0] d; logic [31:0] e;} row_type;
   row_type rows [16] = '{
      '{1, 12'h440, 0, 5'h01, 32'hffffffff, 32'h0},
      '{1, 12'h440, 0, 5'h02, 32'hffffffff, 32'hf0f0f0f0},
      '{1, 12'h410, 0, 5'h07, 32'hffffffff, 32'h0},
      '{1, 12'h400, 0, 5'h07, 32'h30201000, 32'h30201000},
      '{0, 12'h400, 1, 5'h07, 32'h0, 32'h0},
      '{1, 12'h820, 0, 5'h07, 32'hff0e0302, 32'h0f0e0302},
      '{1, 12'h800, 0, 5'h07, 32'hffffffff, 32'h0},
      '{1, 12'h81c, 1, 5'h07, 32'hffffffff, 32'h02020200},
      '{0, 12'h81c, 3, 5'h07, 32'h0, 32'h08080800},
      '{1, 12'hc00, 0, 5'h07, 32'h55555555, 32'hffffffff},
      '{1, 12'hc04, 2, 5'h07, 32'hffffffff, 32'h28000000},
      '{1, 12'hc08, 0, 5'h07, 32'ha5a5a5a5, 32'ha5a5a5a5},
      '{0, 12'hd00, 0, 5'h07, 32'h0, 32'h0},
      '{0, 12'hd04, 0, 5'h07, 32'h0, 32'h0000a5c3},
      '{1, 12'he00, 0, 5'h07, 32'hffffffff, 32'h0},
      '{1, 12'hf00, 0, 5'h07, 32'h0, 32'h0}};
   logic [3:0] dests [4] = '{4'b1001, 4'b1011, 4'b0100, 4'b0000};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   apb_req_type bus_in = '0;
   apb_rsp_type bus_out;
   logic [1:0] access_core = 2'h0;
   logic [4:0] line_count_field = 5'h07;
   logic [1:0] core_count = 2'h3;
   logic [3:0] legacy_n = 4'hf;
   logic [NUM_SPI-1:0] irq_lines = 224'ha5c3;
   logic [3:0] model_en = 4'hf;
   logic [3:0] model_delay = 4'h1;
   core_ack_type [3:0] ack;
   core_req_type [3:0] req;
   logic [31:0] rdata;
   logic [3:0] last_prio [4];
   logic [1:0] last_src [4];
   int hits [4][1024];
   int acks [4][1024];
   int mismatches = 0;
   int compares = 0;
   irq_distributor i_dut (.pclk(pclk), .presetn(presetn), .bus_in(bus_in),
      .access_core(access_core), .bus_out(bus_out), .line_count_field(line_count_field),
      .core_count(core_count), .irq_lines(irq_lines), .private_lines('0),
      .legacy_irq_pin_n(legacy_n),
      .ack(ack), .req(req));
   irq_core_model i_cores (.pclk(pclk), .presetn(presetn), .enable(model_en),
      .delay(model_delay), .req(req), .ack(ack));
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      for (int c = 0; c < 4; c++) begin
         if (req[c].valid === 1'b1) begin
            hits[c][req[c].id]++;
            last_prio[c] = req[c].prio;
            last_src[c] = req[c].src;
         end
         if (ack[c].take === 1'b1) acks[c][ack[c].id]++;
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic clear();
      hits = '{default: 0};
      acks = '{default: 0};
   endtask
   // one idle edge after each transfer keeps a driver from hitting psel twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [1:0] core,
      input logic [31:0] d);
      int n;
      n = 0;
      bus_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      access_core <= core;
      @(posedge pclk);
      bus_in.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (bus_out.pready !== 1'b1 && n < 16);
      rdata = bus_out.prdata;
      bus_in.psel <= 1'b0;
      bus_in.penable <= 1'b0;
      @(posedge pclk);
      check("ready", n < 16, 1);
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      close_out();
   end
   initial begin
      wait_cycles(3);
      presetn <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         line_count_field <= rows[i].lc;
         if (rows[i].w) apb(1'b1, rows[i].a, rows[i].core, rows[i].d);
         apb(1'b0, rows[i].a, rows[i].core, 32'h0);
         check("register read", rdata, rows[i].e);
      end
      irq_lines <= '0;
      wait_cycles(20);
      // bits 23:20 stay zero in every trigger word
      for (int f = 0; f < 4; f++) begin
         clear();
         apb(1'b1, SWTRIG_ADDR, 2'h2, {6'h0, 2'(f), 4'h0, 4'b1001, 6'h0, 10'd3});
         wait_cycles(12);
         for (int c = 0; c < 4; c++) begin
            check("dest", hits[c][3] != 0, dests[f][c]);
         end
      end
      apb(1'b1, 12'h404, 2'h0, 32'h00f07000);
      apb(1'b1, 12'h404, 2'h1, 32'h00002000);
      apb(1'b1, SWTRIG_ADDR, 2'h3, 32'h00030005);
      wait_cycles(12);
      check("prio core0", last_prio[0], 4'h7);
      check("prio core1", last_prio[1], 4'h2);
      check("source", last_src[1], 2'h3);
      clear();
      apb(1'b1, SWTRIG_ADDR, 2'h0, 32'h02000006);
      wait_cycles(12);
      check("lowest prio", hits[0][6], 0);
      for (int k = 0; k < 2; k++) begin
         line_count_field <= k ? 5'h01 : 5'h07;
         clear();
         apb(1'b1, SWTRIG_ADDR, 2'h0, 32'h000400c8);
         wait_cycles(12);
         check("id range", hits[2][200] != 0, k == 0);
         check("stored route", hits[1][200], 0);
      end
      // only two cores present: mask bits for cores 2 and 3 must do nothing
      core_count <= 2'h1;
      clear();
      apb(1'b1, SWTRIG_ADDR, 2'h1, 32'h000f0004);
      wait_cycles(12);
      check("absent core", hits[3][4], 0);
      check("present core", hits[0][4] != 0, 1);
      core_count <= 2'h3;
      line_count_field <= 5'h07;
      model_en <= 4'h0;
      // id 33 one level less urgent, so id 36 wins on core 0 despite the higher id
      apb(1'b1, 12'h420, 2'h0, 32'h00001000);
      apb(1'b1, 12'h824, 2'h0, 32'h1);
      clear();
      apb(1'b1, 12'h284, 2'h0, 32'h12);
      apb(1'b1, 12'h824, 2'h0, 32'h2);
      wait_cycles(8);
      check("old route", hits[0][36] != 0, 1);
      check("new route", hits[1][36], 0);
      check("set pend", hits[1][33] != 0, 1);
      model_en <= 4'b0001;
      wait_cycles(16);
      clear();
      wait_cycles(8);
      check("one core", hits[1][33], 0);
      model_en <= 4'hf;
      model_delay <= 4'h6;
      clear();
      irq_lines <= 224'h5;
      wait_cycles(60);
      irq_lines <= '0;
      // id 34 waits behind the level line, up to two acknowledge periods
      wait_cycles(30);
      check("level again", acks[1][32] > 1, 1);
      check("edge once", acks[1][34], 1);
      clear();
      legacy_n <= 4'b0111;
      wait_cycles(8);
      check("legacy low", hits[3][31] != 0, 1);
      check("legacy other", hits[2][31], 0);
      legacy_n <= 4'hf;
      presetn <= 1'b0;
      wait_cycles(2);
      check("req in reset", req[0], 0);
      presetn <= 1'b1;
      wait_cycles(1);
      apb(1'b0, 12'h820, 2'h0, 32'h0);
      check("route reset", rdata, 32'h0);
      close_out();
   end
endmodule
`default_nettype wire

// ---- irq_distributor_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_distributor_sva
   import irq_dist_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire apb_req_type bus_in,
   input wire logic [1:0] access_core,
   input wire apb_rsp_type bus_out,
   // configuration, lines and cores
   input wire logic [1:0] core_count,
   input wire logic [NUM_SPI-1:0] irq_lines,
   input wire core_req_type [3:0] req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup;
   logic rd;
   logic lowest_req;
   assign setup = bus_in.psel && !bus_in.penable;
   assign rd = setup && !bus_in.pwrite;
   always_comb begin
      lowest_req = 1'b0;
      for (int c = 0; c < NUM_CORES; c++) begin
         lowest_req = lowest_req | (req[c].valid && req[c].prio == PRIO_LOWEST);
      end
   end
   a_ready_after_setup: assert property (setup |=> bus_out.pready)
      else $error("no ready after setup");
   a_ready_single: assert property (bus_out.pready |=> !bus_out.pready)
      else $error("ready held two cycles");
   a_no_slverr: assert property (!bus_out.pslverr) else $error("slave error raised");
   a_prio_never_f: assert property (!lowest_req)
      else $error("request at lowest priority");
   a_prio_nibble: assert property (rd && bus_in.paddr inside {[PRIO_BASE:PRIO_LAST]}
      |=> (bus_out.prdata & 32'h0f0f0f0f) == 32'h0) else $error("priority low nibble set");
   a_level_low: assert property (rd && bus_in.paddr == LEVEL_BASE |=>
      bus_out.prdata == 0) else $error("private line levels not zero");
   a_level_raw: assert property (rd && bus_in.paddr == 12'hd04 |=>
      bus_out.prdata == $past(irq_lines[31:0])) else $error("line level mismatch");
   a_route_private: assert property (rd && bus_in.paddr == 12'h81c &&
      access_core <= core_count |=> bus_out.prdata == {{3{8'h01 << $past(access_core)}}, 8'h00})
      else $error("private route read wrong");
   a_cfg_private: assert property (rd && bus_in.paddr == 12'hc04 |=>
      bus_out.prdata[31:26] == 6'b001010) else $error("private config read wrong");
   a_cfg_sgi_edge: assert property (rd && bus_in.paddr == CFG_BASE |=>
      (bus_out.prdata & 32'haaaaaaaa) == 32'haaaaaaaa) else $error("sgi not edge");
   a_trigger_wo: assert property (rd && bus_in.paddr == SWTRIG_ADDR |=>
      bus_out.prdata == 0) else $error("trigger register readable");
endmodule
bind irq_distributor irq_distributor_sva i_sva (.pclk, .presetn, .bus_in, .access_core,
   .bus_out, .core_count, .irq_lines, .req);
`default_nettype wire
